// >>> ptb_pkg.sv
// Package: register map, field layout and timing of the test extension block
package ptb_pkg;
  localparam int CLK_MHZ = 200;
  localparam int CLK_NS = 5;
  localparam logic [7:0] IDX_PRIM = 8'h19;
  localparam logic [7:0] IDX_TEN = 8'h1A;
  localparam logic [7:0] IDX_EXT = 8'h1B;
  localparam logic [7:0] IDX_GC2 = 8'h1C;
  localparam int PRIM_START_BIT = 15;
  localparam int TEN_JAB_BIT = 0;
  localparam int EXT_CONT_BIT = 5;
  localparam int EXT_PEN_BIT = 4;
  localparam int EXT_GAP_BIT = 2;
  localparam int EXT_SEL_LSB = 0;
  localparam int GC2_SRST_BIT = 9;
  localparam logic [15:0] PRIM_WR_MASK = 16'h8000;
  localparam logic [15:0] TEN_WR_MASK = 16'h0001;
  localparam logic [15:0] EXT_WR_MASK = 16'h00FF;
  localparam logic [15:0] GC2_RD_MASK = 16'h0200;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int GAP_LONG_US = 15;
  localparam int GAP_SHORT_US = 10;
  localparam int GAP_LONG_CYC = GAP_LONG_US * CLK_MHZ;
  localparam int GAP_SHORT_CYC = GAP_SHORT_US * CLK_MHZ;
  localparam int BIT_NS = 100;
  localparam int HALF_CYC = BIT_NS / (2 * CLK_NS);
  localparam logic [1:0] PAT_END_PACKET_TYPE0 = 2'h0;
  localparam logic [1:0] PAT_END_PACKET_TYPE1 = 2'h1;
  localparam logic [1:0] PAT_NLP = 2'h2;
  localparam logic [1:0] PAT_TONE = 2'h3;
  localparam int END_PACKET_TYPE0_HALVES = 4;
  localparam int END_PACKET_TYPE1_HALVES = 6;
  localparam int NLP_HALVES = 2;
  localparam logic [8:0] LFSR_SEED = 9'h1FF;

  function automatic logic [8:0] lfsr_step(input logic [8:0] v);
    lfsr_step = {v[7:0], v[8] ^ v[4]};
  endfunction
endpackage

// >>> ptb_tst_if.sv
// Interface: controls from the register file to the two test generators
interface ptb_tst_if;
  logic srst;
  logic pen;
  logic [1:0] psel;
  logic gap;
  logic p_drive;
  logic p_level;
  logic run;
  logic cont;
  logic tx_en;
  logic [3:0] tx_nib;
  modport ctl (output srst, pen, psel, gap, run, cont, input p_drive, p_level, tx_en, tx_nib);
  modport pat (input srst, pen, psel, gap, output p_drive, p_level);
  modport bist (input srst, run, cont, output tx_en, tx_nib);
endinterface

// >>> ptb_bist_tx.sv
// Self-test transmitter: pseudo-random nibble packets, gapless in continuous mode
module ptb_bist_tx
  import ptb_pkg::*;
#(
  parameter int PKT_NIBBLES = 128,
  parameter int IPG_NIBBLES = 24,
  parameter int NIB_DIV = 8
)(
  input wire logic sys_clk,
  input wire logic reset_n,
  ptb_tst_if.bist b
);
  typedef enum logic {BT_SEND, BT_GAP} ptb_bt_state_t;
  typedef struct packed {
    ptb_bt_state_t st;
    logic [7:0] div;
    logic [11:0] cnt;
    logic [8:0] lfsr;
    logic tx_en;
    logic [3:0] nib;
  } ptb_bt_t;
  ptb_bt_t s, n;
  logic ne;
  logic [8:0] nl;

  always_comb
  begin
    n = s;
    nl = s.lfsr;
    ne = (s.div == 8'(NIB_DIV - 1));
    n.div = ne ? 8'h00 : s.div + 8'h01;
    if (!b.run || b.srst)
    begin
      n = '0;
      n.lfsr = LFSR_SEED;
    end
    else if (ne)
    begin
      n.cnt = s.cnt + 12'h001;
      case (s.st)
        BT_SEND:
        begin
          for (int i = 0; i < 4; i++)
            nl = lfsr_step(nl);
          n.lfsr = nl;
          n.nib = s.lfsr[3:0];
          n.tx_en = 1'b1;
          if (s.cnt == 12'(PKT_NIBBLES - 1))
          begin
            n.cnt = 12'h000;
            n.st = b.cont ? BT_SEND : BT_GAP;
          end
        end
        BT_GAP:
        begin
          n.tx_en = 1'b0;
          if (s.cnt == 12'(IPG_NIBBLES - 1))
          begin
            n.cnt = 12'h000;
            n.st = BT_SEND;
          end
        end
        default: n = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= n;
  end

  assign b.tx_en = s.tx_en;
  assign b.tx_nib = s.nib;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence cont_held;
    b.cont && b.run && !b.srst;
  endsequence
  a_cont_no_gap:
  assert property (((s.tx_en && s.st == BT_SEND) and cont_held) ##1 cont_held
    |-> s.tx_en && s.st == BT_SEND)
    else $error("transmit stopped in continuous mode");
endmodule

// >>> ptb_pattern_gen.sv
// Cable-driver test pattern generator with selectable gap between sequences
module ptb_pattern_gen
  import ptb_pkg::*;
#(
  parameter int DATA_HALVES = 128
)(
  input wire logic sys_clk,
  input wire logic reset_n,
  ptb_tst_if.pat p
);
  typedef enum logic [1:0] {PG_IDLE, PG_DATA, PG_EOP, PG_GAP} ptb_pg_state_t;
  typedef struct packed {
    ptb_pg_state_t st;
    logic [7:0] div;
    logic [7:0] hcnt;
    logic [11:0] tmr;
    logic ph;
    logic [8:0] lfsr;
    logic [1:0] sel;
    logic drive;
    logic level;
  } ptb_pg_t;
  localparam logic [11:0] TMR_LONG = 12'(GAP_LONG_CYC - 1);
  localparam logic [11:0] TMR_SHORT = 12'(GAP_SHORT_CYC - 1);
  ptb_pg_t s, n;
  logic he;
  logic [8:0] nl;
  logic [11:0] tload;

  always_comb
  begin
    n = s;
    nl = lfsr_step(s.lfsr);
    tload = p.gap ? TMR_LONG : TMR_SHORT;
    he = (s.div == 8'(HALF_CYC - 1));
    n.div = he ? 8'h00 : s.div + 8'h01;
    // Disabled leaves the driver path to normal traffic
    if (!p.pen || p.srst)
      n = '0;
    else
      case (s.st)
        PG_IDLE:
        begin
          n.st = PG_DATA;
          n.sel = p.psel;
          n.hcnt = 8'h00;
          n.ph = 1'b0;
          n.div = 8'h00;
          n.lfsr = LFSR_SEED;
          n.drive = 1'b1;
          n.level = (p.psel == PAT_NLP);
        end
        PG_DATA:
          if (he)
          begin
            n.ph = ~s.ph;
            n.hcnt = s.hcnt + 8'h01;
            case (s.sel)
              PAT_TONE: n.level = ~s.ph;
              PAT_NLP:
                if (s.hcnt == 8'(NLP_HALVES - 1))
                begin
                  n.st = PG_GAP;
                  n.drive = 1'b0;
                  n.level = 1'b0;
                  n.tmr = tload;
                end
              default:
              begin
                if (s.ph)
                begin
                  n.lfsr = nl;
                  n.level = ~nl[0];
                end
                else
                  n.level = s.lfsr[0];
                if (s.hcnt == 8'(DATA_HALVES - 1))
                begin
                  n.st = PG_EOP;
                  n.hcnt = 8'h00;
                  n.level = 1'b1;
                end
              end
            endcase
          end
        PG_EOP:
          if (he)
          begin
            n.hcnt = s.hcnt + 8'h01;
            if (s.hcnt == 8'((s.sel == PAT_END_PACKET_TYPE1) ? END_PACKET_TYPE1_HALVES - 1 : END_PACKET_TYPE0_HALVES - 1))
            begin
              n.st = PG_GAP;
              n.drive = 1'b0;
              n.level = 1'b0;
              n.tmr = tload;
            end
          end
        PG_GAP:
        begin
          n.tmr = s.tmr - 12'h001;
          if (s.tmr == 12'h000)
            n.st = PG_IDLE;
        end
        default: n = '0;
      endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= n;
  end

  assign p.p_drive = s.drive;
  assign p.p_level = s.level;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence enter_gap;
    (s.st != PG_GAP) ##1 (s.st == PG_GAP);
  endsequence
  a_gap_length:
  assert property (enter_gap |-> s.tmr == ($past(p.gap) ? TMR_LONG : TMR_SHORT))
    else $error("gap timer loaded with wrong length");
  a_off_quiet:
  assert property (!p.pen |=> !s.drive && !s.level)
    else $error("driver pattern active while disabled");
  a_tone_toggle:
  assert property (s.st == PG_DATA && s.sel == PAT_TONE && he && p.pen && !p.srst
    |=> s.level != $past(s.level) && s.st == PG_DATA)
    else $error("tone pattern did not toggle");
endmodule

// >>> ptb_test_ext_top.sv
// Top: AXI4-Lite register file, self-test error counter and soft reset
// Operation
// - While self-test runs, each errored received nibble bumps the count in bits 15:8.
// - Starting self-test again clears the error count to zero.
// - The error count sticks at its maximum instead of wrapping.
// - Continuous bit 5 makes the self-test transmitter send random data with no gaps.
// - Continuous mode only acts together with the start bit in the primary control register.
// - Bit 4 enables the cable-driver test pattern, and resets to zero.
// - Bit 2 picks a 15 us gap when set and a 10 us gap when clear.
// - Bits 1:0 pick end type 0, end type 1, link pulses or the tone that toggles every half bit.
// - Writing bit 9 restarts the device logic and zeroes the error count but keeps the control registers, then clears.
// - Second control register bits 15:10 and 8:0 ignore writes and read zero.
module ptb_test_ext_top
  import ptb_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int SRST_CYC = 16,
  parameter int PKT_NIBBLES = 128,
  parameter int IPG_NIBBLES = 24,
  parameter int NIB_DIV = 8,
  parameter int DATA_HALVES = 128
)(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_nib_err,
  output logic selftest_tx_en,
  output logic [3:0] selftest_tx_nib,
  output logic selftest_run,
  output logic driver_pattern_active,
  output logic driver_pattern_drive,
  output logic driver_pattern_level,
  output logic jabber_disable,
  output logic soft_reset_active
);
  typedef struct packed {
    logic aw_got;
    logic aw_ok;
    logic [7:0] aw_idx;
    logic w_got;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] r_idx;
    logic [15:0] rdata;
    logic [1:0] rresp;
    logic [15:0] prim;
    logic [15:0] ten;
    logic [7:0] ext;
    logic [7:0] cnt;
    logic [7:0] srst_cnt;
    logic srst;
    logic run;
    logic cont;
    logic pen;
  } ptb_top_t;

  ptb_top_t s, n;
  logic restart;
  ptb_tst_if tif ();

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers for the read and the write path

  function automatic logic reg_ok(input logic [ADDR_W-1:0] a);
    reg_ok = (a[ADDR_W-1:10] == '0) &&
      (a[9:2] inside {IDX_PRIM, IDX_TEN, IDX_EXT, IDX_GC2});
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] d,
    input logic [15:0] m, input logic [1:0] b);
    logic [15:0] be;
    be = {{8{b[1]}}, {8{b[0]}}} & m;
    merge = (o & ~be) | (d & be);
  endfunction

  function automatic logic [15:0] rd_mux(input ptb_top_t v, input logic [7:0] i);
    case (i)
      IDX_PRIM: rd_mux = v.prim;
      IDX_TEN: rd_mux = v.ten;
      IDX_EXT: rd_mux = {v.cnt, v.ext};
      IDX_GC2: rd_mux = GC2_RD_MASK & {6'h00, v.srst, 9'h000};
      default: rd_mux = 16'h0000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    n = s;
    restart = 1'b0;
    // Write address and data may arrive in either order
    if (s_axi_awvalid && s.awready)
    begin
      n.aw_got = 1'b1;
      n.aw_ok = reg_ok(s_axi_awaddr);
      n.aw_idx = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && s.wready)
    begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata[15:0];
      n.wstrb = s_axi_wstrb[1:0];
    end
    if (s.bvalid && s_axi_bready)
      n.bvalid = 1'b0;
    // Soft reset counts down; a new write below reloads it
    if (s.srst_cnt != 8'h00)
      n.srst_cnt = s.srst_cnt - 8'h01;
    if (s.aw_got && s.w_got && !s.bvalid)
    begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = s.aw_ok ? RESP_OKAY : RESP_SLVERR;
      if (s.aw_ok)
        case (s.aw_idx)
          IDX_PRIM: n.prim = merge(s.prim, s.wdata, PRIM_WR_MASK, s.wstrb);
          IDX_TEN: n.ten = merge(s.ten, s.wdata, TEN_WR_MASK, s.wstrb);
          IDX_EXT: n.ext = 8'(merge({8'h00, s.ext}, s.wdata, EXT_WR_MASK, s.wstrb));
          IDX_GC2:
            if (s.wstrb[1] && s.wdata[GC2_SRST_BIT])
              n.srst_cnt = 8'(SRST_CYC);
          default: n.bresp = RESP_SLVERR;
        endcase
    end
    n.srst = (n.srst_cnt != 8'h00);
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;

    // Read: one outstanding, answered the cycle after the address is taken
    if (s.rvalid && s_axi_rready)
      n.rvalid = 1'b0;
    if (s_axi_arvalid && s.arready)
    begin
      n.rvalid = 1'b1;
      n.r_idx = s_axi_araddr[9:2];
      n.rdata = reg_ok(s_axi_araddr) ? rd_mux(s, s_axi_araddr[9:2]) : 16'h0000;
      n.rresp = reg_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    n.arready = !n.rvalid;

    // Soft reset halts the generators and clears the error count but leaves the control registers intact
    n.run = n.prim[PRIM_START_BIT] && !n.srst;
    n.cont = n.ext[EXT_CONT_BIT] && n.run;
    n.pen = n.ext[EXT_PEN_BIT] && !n.srst;
    restart = n.run && !s.run;
    if (restart || s.srst)
      n.cnt = 8'h00;
    else if (s.run && rx_nib_err && s.cnt != 8'hFF)
      n.cnt = s.cnt + 8'h01;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Generators

  assign tif.srst = s.srst;
  assign tif.pen = s.pen;
  assign tif.psel = s.ext[EXT_SEL_LSB +: 2];
  assign tif.gap = s.ext[EXT_GAP_BIT];
  assign tif.run = s.run;
  assign tif.cont = s.cont;

  ptb_bist_tx #(
    .PKT_NIBBLES(PKT_NIBBLES),
    .IPG_NIBBLES(IPG_NIBBLES),
    .NIB_DIV(NIB_DIV)
  ) u_bist (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .b(tif.bist)
  );

  ptb_pattern_gen #(
    .DATA_HALVES(DATA_HALVES)
  ) u_pat (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .p(tif.pat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = {16'h0000, s.rdata};
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign selftest_tx_en = tif.tx_en;
  assign selftest_tx_nib = tif.tx_nib;
  assign selftest_run = s.run;
  assign driver_pattern_active = s.pen;
  assign driver_pattern_drive = tif.p_drive;
  assign driver_pattern_level = tif.p_level;
  // Jabber logic lives elsewhere; software must set this before 10 Mb/s continuous use
  assign jabber_disable = s.ten[TEN_JAB_BIT];
  assign soft_reset_active = s.srst;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_cnt_counts:
  assert property (s.run && rx_nib_err && s.cnt != 8'hFF && !restart && !s.srst
    |=> s.cnt == $past(s.cnt) + 8'h01)
    else $error("errored nibble not counted");
  a_cnt_clear:
  assert property ($rose(s.run) |-> s.cnt == 8'h00)
    else $error("count not cleared at restart");
  a_cnt_sticks:
  assert property (s.cnt == 8'hFF && !restart && !s.srst |=> s.cnt == 8'hFF)
    else $error("error count wrapped");
  a_cont_gated:
  assert property (s.cont |-> s.run && s.prim[PRIM_START_BIT] && s.ext[EXT_CONT_BIT])
    else $error("continuous mode without start control");
  sequence srst_write;
    s.aw_got && s.w_got && !s.bvalid && s.aw_ok && s.aw_idx == IDX_GC2
      && s.wstrb[1] && s.wdata[GC2_SRST_BIT];
  endsequence
  a_srst_self_clear:
  assert property (srst_write |=> s.srst && !s.pen && !s.run ##[1:64] !s.srst)
    else $error("soft reset did not assert or clear");
  a_srst_keeps_regs:
  assert property (s.srst && !(s.aw_got && s.w_got && !s.bvalid)
    |=> s.ext == $past(s.ext) && s.prim == $past(s.prim))
    else $error("soft reset altered configuration");
  a_gc2_reads_zero:
  assert property (s.rvalid && s.r_idx == IDX_GC2 |-> (s.rdata & ~GC2_RD_MASK) == 16'h0000)
    else $error("reserved bits of second control register read nonzero");
endmodule

// >>> ptb_test_ext_top_tb.sv
// Testbench: register access, error counter, self-test transmit, pattern and soft reset
module ptb_test_ext_top_tb
  import ptb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SRST_N = 4;
  localparam int ND = 2;
  localparam int DH = 8;
  logic sys_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, selftest_tx_nib;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic rx_nib_err, selftest_tx_en, selftest_run, driver_pattern_active;
  logic driver_pattern_drive, driver_pattern_level, jabber_disable, soft_reset_active;
  int failures = 0;
  int num_checks = 0;
  int srst_cnt = 0;
  int hi, lo, n;
  //////////////////////////////////////////////////////////////////////////////////////////
  ptb_test_ext_top #(.ADDR_W(12), .SRST_CYC(SRST_N), .PKT_NIBBLES(4), .IPG_NIBBLES(2),
    .NIB_DIV(ND), .DATA_HALVES(DH)) dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_nib_err(rx_nib_err),
    .selftest_tx_en(selftest_tx_en), .selftest_tx_nib(selftest_tx_nib),
    .selftest_run(selftest_run), .driver_pattern_active(driver_pattern_active),
    .driver_pattern_drive(driver_pattern_drive), .driver_pattern_level(driver_pattern_level),
    .jabber_disable(jabber_disable), .soft_reset_active(soft_reset_active));
  //////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Counts every cycle the soft reset stands, so a late start still gets measured
  always @(posedge sys_clk)
    if (soft_reset_active === 1'b1)
      srst_cnt <= srst_cnt + 1;
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d, output logic [1:0] resp);
    int k;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    k = 0;
    while (k < 1000)
    begin
      @(posedge sys_clk);
      k++;
      if (s_axi_awvalid && s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
        break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k >= 1000)
      chk("write answer", 32'h1, 32'h0);
  endtask
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp,
    input logic [1:0] eresp);
    int k;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k = 0;
    while (k < 1000)
    begin
      @(posedge sys_clk);
      k++;
      if (s_axi_arvalid && s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
        break;
    end
    s_axi_rready <= 1'b0;
    chk(nm, exp, s_axi_rdata);
    chk({nm, " resp"}, {30'h0, eresp}, {30'h0, s_axi_rresp});
  endtask
  task automatic errs(input int cnt);
    repeat (cnt)
    begin
      @(posedge sys_clk);
      rx_nib_err <= 1'b1;
      @(posedge sys_clk);
      rx_nib_err <= 1'b0;
    end
  endtask
  task automatic wait_drive(input logic v);
    int k;
    k = 0;
    while (driver_pattern_drive !== v && k < 5000)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 5000)
      chk("pattern drive wait", {31'h0, v}, {31'h0, ~v});
  endtask
  // Counts cycles over a window where the watched line sits at the given level
  task automatic span(input int which, input logic v, input int len, output int cnt);
    cnt = 0;
    repeat (len)
    begin
      @(posedge sys_clk);
      if ((which == 0 ? selftest_tx_en : driver_pattern_drive) === v)
        cnt++;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #400us;
    failures++;
    give_verdict();
  end
  initial
  begin
    reset_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
    rx_nib_err = 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rd_chk("ext reset", 12'h06C, 32'h0, RESP_OKAY);
    rd_chk("gc2 reset", 12'h070, 32'h0, RESP_OKAY);
    wr(12'h06C, 16'hFFFF, r);
    rd_chk("ext count read only", 12'h06C, 32'h00FF, RESP_OKAY);
    chk("pattern active on", 32'h1, {31'h0, driver_pattern_active});
    wr(12'h06C, 16'h0007, r);
    repeat (2) @(posedge sys_clk);
    chk("pattern active off", 32'h0, {31'h0, driver_pattern_active});
    span(1, 1'b1, 200, n);
    chk("drive while disabled", 32'h0, n);
    wr(12'h070, 16'hFDFF, r);
    rd_chk("gc2 reserved", 12'h070, 32'h0, RESP_OKAY);
    chk("no soft reset", 32'h0, srst_cnt);
    wr(12'h040, 16'h1234, r);
    chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    rd_chk("unmapped read", 12'h040, 32'h0, RESP_SLVERR);
    wr(12'h068, 16'h0001, r);
    chk("jabber disable", 32'h1, {31'h0, jabber_disable});
    wr(12'h064, 16'h8000, r);
    repeat (2) @(posedge sys_clk);
    chk("run", 32'h1, {31'h0, selftest_run});
    errs(5);
    rd_chk("count five", 12'h06C, 32'h0507, RESP_OKAY);
    errs(300);
    rd_chk("count saturated", 12'h06C, 32'hFF07, RESP_OKAY);
    wr(12'h064, 16'h0000, r);
    wr(12'h064, 16'h8000, r);
    rd_chk("count restart", 12'h06C, 32'h0007, RESP_OKAY);
    span(0, 1'b0, 40, n);
    chk("packet gaps present", 32'h1, {31'h0, n != 0});
    wr(12'h06C, 16'h0020, r);
    // A gap already begun when the bit lands still runs out
    repeat (12) @(posedge sys_clk);
    span(0, 1'b0, 60, n);
    chk("continuous no gap", 32'h0, n);
    wr(12'h064, 16'h0000, r);
    repeat (40) @(posedge sys_clk);
    chk("continuous needs run", 32'h0, {31'h0, selftest_tx_en});
    // Restart from the seed: first nibbles of the x9+x5 sequence are F, 0, 7
    wr(12'h064, 16'h8000, r);
    n = 0;
    while (selftest_tx_en !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("first nibble", 32'hF, {28'h0, selftest_tx_nib});
    repeat (ND) @(posedge sys_clk);
    chk("second nibble", 32'h0, {28'h0, selftest_tx_nib});
    repeat (ND) @(posedge sys_clk);
    chk("third nibble", 32'h7, {28'h0, selftest_tx_nib});
    // Modes 0..2, gap long only for mode 1, so both gap lengths are seen
    for (int m = 0; m < 3; m++)
    begin
      wr(12'h06C, 16'h0010 | ((m == 1) ? 16'h0004 : 16'h0000) | m[15:0], r);
      wait_drive(1'b0);
      wait_drive(1'b1);
      span(1, 1'b1, 1, hi);
      while (driver_pattern_drive === 1'b1 && hi < 5000)
      begin
        @(posedge sys_clk);
        hi++;
      end
      lo = 0;
      while (driver_pattern_drive === 1'b0 && lo < 5000)
      begin
        @(posedge sys_clk);
        lo++;
      end
      chk("sequence length", (m == 2) ? NLP_HALVES * HALF_CYC :
        (DH + ((m == 0) ? END_PACKET_TYPE0_HALVES : END_PACKET_TYPE1_HALVES)) * HALF_CYC, hi);
      chk("gap length", ((m == 1) ? GAP_LONG_CYC : GAP_SHORT_CYC) + 1, lo);
    end
    wr(12'h06C, 16'h0013, r);
    // Select takes hold only at the next sequence start, after the current gap
    wait_drive(1'b0);
    wait_drive(1'b1);
    repeat (30) @(posedge sys_clk);
    hi = driver_pattern_level;
    n = 0;
    while (driver_pattern_level === hi[0] && n < 100)
    begin
      @(posedge sys_clk);
      n++;
    end
    hi = driver_pattern_level;
    lo = 0;
    while (driver_pattern_level === hi[0] && lo < 100)
    begin
      @(posedge sys_clk);
      lo++;
    end
    chk("tone half period", HALF_CYC, lo);
    span(1, 1'b0, 100, n);
    chk("tone no gap", 32'h0, n);
    wr(12'h064, 16'h8000, r);
    wr(12'h06C, 16'h0035, r);
    errs(3);
    srst_cnt = 0;
    wr(12'h070, 16'h0200, r);
    repeat (SRST_N + 6) @(posedge sys_clk);
    chk("soft reset length", SRST_N, srst_cnt);
    rd_chk("soft reset cleared", 12'h070, 32'h0, RESP_OKAY);
    rd_chk("ext kept count reset", 12'h06C, 32'h0035, RESP_OKAY);
    rd_chk("start kept", 12'h064, 32'h8000, RESP_OKAY);
    chk("run after soft reset", 32'h1, {31'h0, selftest_run});
    chk("pattern after soft reset", 32'h1, {31'h0, driver_pattern_active});
    give_verdict();
  end
endmodule
